// file: src/serial_eeprom_bus_front_end.sv
// two-wire eeprom target front end: framing, address decode, write cycle
// Notes on behaviour
// - data changes with clock high are conditions
// - falling data, clock high, is start
// - rising data, clock high, is stop
// - stop after read returns to standby
// - eight-bit words, ninth clock acknowledges
// - standby at power-up and after stop, except a stop that ends a write of unprotected bytes
// - address top nibble must match type
// - address bits 3..1 match select pins
// - address bit 0 high means read
// - match acks, mismatch releases and idles
// - write-protect high inhibits array writes
// - write cycle starts at stop, within 5 ms
// - inputs ignored, no ack while writing
// - 128 pages of 32 bytes, 12-bit address
`timescale 1ns/1ns
module serial_eeprom_bus_front_end #(
  parameter logic [3:0] DEV_TYPE = eeprom_fe_pkg::DEV_TYPE_DEFAULT,
  parameter int unsigned WRITE_CYCLES = eeprom_fe_pkg::WRITE_CYCLE_CYCLES
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // straps and protect
  input wire logic select_pin_high_i,
  input wire logic select_pin_mid_i,
  input wire logic select_pin_low_i,
  input wire logic write_protect_i,
  // user side: data path hooks
  input wire logic tx_bit_i,
  input wire logic tx_en_i,
  output logic [7:0] rx_word_o,
  output logic rx_valid_o,
  output logic selected_o,
  output logic read_mode_o,
  output logic writing_o,
  output logic standby_o,
  output logic array_write_o
);
  import eeprom_fe_pkg::*;

  localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);

  bus_evt_s evt;
  logic [2:0] straps_s1_reg, straps_reg;
  logic wp_s1_reg, wp_reg;
  fe_state_e state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic rw_reg, rw_next;
  logic dirty_reg, dirty_next;
  logic [CNT_W-1:0] wr_cnt_reg, wr_cnt_next;
  logic pull_reg, pull_next;
  logic rx_valid_next, array_write_next;
  logic [7:0] rx_word_next;
  dev_addr_s addr_word;
  logic addr_match;

  bus_line_sync u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .evt_o(evt)
  );

  assign addr_word = dev_addr_s'(shift_reg);
  assign addr_match = (addr_word.dev_type == DEV_TYPE) && (addr_word.select == straps_reg);

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    rw_next = rw_reg;
    dirty_next = dirty_reg;
    wr_cnt_next = wr_cnt_reg;
    pull_next = pull_reg;
    rx_valid_next = 1'b0;
    rx_word_next = rx_word_o;
    array_write_next = 1'b0;
    case (state_reg)
      ST_WRITING: begin
        pull_next = 1'b0;
        if (wr_cnt_reg == CNT_W'(WRITE_CYCLES - 1)) begin
          state_next = ST_STANDBY;
          wr_cnt_next = '0;
        end else begin
          wr_cnt_next = wr_cnt_reg + CNT_W'(1);
        end
      end
      default: begin
        if (evt.start) begin
          state_next = ST_ADDR;
          bit_cnt_next = BIT_CNT_RST;
          pull_next = 1'b0;
          dirty_next = 1'b0;
        end else if (evt.stop) begin
          pull_next = 1'b0;
          bit_cnt_next = BIT_CNT_RST;
          if (state_reg != ST_STANDBY && !rw_reg && dirty_reg) begin
            state_next = ST_WRITING;
            wr_cnt_next = '0;
          end else begin
            state_next = ST_STANDBY;
          end
          dirty_next = 1'b0;
        end else if (state_reg != ST_STANDBY) begin
          if (evt.clk_rise) begin
            // rises counted, so the start's own fall is no bit
            if (bit_cnt_reg <= ACK_BIT) begin
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
            if (bit_cnt_reg < ACK_BIT) begin
              shift_next = {shift_reg[6:0], evt.data};
            end
          end
          if (evt.clk_fall) begin
            if (bit_cnt_reg == ACK_BIT + 4'h1) begin
              bit_cnt_next = BIT_CNT_RST;
              pull_next = 1'b0;
              if (state_reg == ST_ACK) begin
                state_next = ST_ACTIVE;
                // first read bit pulls low only
                pull_next = rw_reg && tx_en_i && !tx_bit_i;
              end
              if (state_reg == ST_ACTIVE && rw_reg) begin
                // controller acknowledge missing ends the read
                state_next = evt.data ? ST_STANDBY : ST_ACTIVE;
                pull_next = !evt.data && tx_en_i && !tx_bit_i;
              end
            end else if (bit_cnt_reg == ACK_BIT) begin
              if (state_reg == ST_ADDR) begin
                if (addr_match) begin
                  state_next = ST_ACK;
                  rw_next = shift_reg[ADDR_RW_BIT];
                  pull_next = 1'b1;
                end else begin
                  state_next = ST_STANDBY;
                  pull_next = 1'b0;
                end
              end else if (!rw_reg) begin
                pull_next = 1'b1;
                rx_valid_next = 1'b1;
                // word address bytes leave here too
                rx_word_next = shift_reg;
                array_write_next = ~wp_reg;
                dirty_next = dirty_reg | ~wp_reg;
              end else begin
                pull_next = 1'b0;
              end
            end else begin
              pull_next = (state_reg == ST_ACTIVE) && rw_reg && tx_en_i && !tx_bit_i;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_STANDBY;
      bit_cnt_reg <= BIT_CNT_RST;
      shift_reg <= '0;
      rw_reg <= 1'b0;
      dirty_reg <= 1'b0;
      wr_cnt_reg <= '0;
      pull_reg <= 1'b0;
      straps_s1_reg <= '0;
      straps_reg <= '0;
      wp_s1_reg <= 1'b0;
      wp_reg <= 1'b0;
      rx_word_o <= '0;
      rx_valid_o <= 1'b0;
      array_write_o <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      rw_reg <= rw_next;
      dirty_reg <= dirty_next;
      wr_cnt_reg <= wr_cnt_next;
      pull_reg <= pull_next;
      straps_s1_reg <= {select_pin_high_i, select_pin_mid_i, select_pin_low_i};
      straps_reg <= straps_s1_reg;
      wp_s1_reg <= write_protect_i;
      wp_reg <= wp_s1_reg;
      rx_word_o <= rx_word_next;
      rx_valid_o <= rx_valid_next;
      array_write_o <= array_write_next;
    end
  end

  // registered bus drive and status outputs
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      selected_o <= 1'b0;
      read_mode_o <= 1'b0;
      writing_o <= 1'b0;
      standby_o <= 1'b1;
    end else if (ce_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= pull_next;
      selected_o <= (state_next == ST_ACK) || (state_next == ST_ACTIVE);
      read_mode_o <= rw_next;
      writing_o <= state_next == ST_WRITING;
      standby_o <= state_next == ST_STANDBY;
    end
  end
endmodule

// file: include/eeprom_fe_pkg.sv
// shared constants and types for the two-wire eeprom front end
package eeprom_fe_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // device type identifier, value arbitrary
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
  localparam int unsigned ADDR_TYPE_MSB = 7;
  localparam int unsigned ADDR_TYPE_LSB = 4;
  localparam int unsigned ADDR_SEL_MSB = 3;
  localparam int unsigned ADDR_SEL_LSB = 1;
  localparam int unsigned ADDR_RW_BIT = 0;
  localparam int unsigned PAGE_COUNT = 128;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned WORD_ADDR_BITS = 12;
  localparam int unsigned WRITE_CYCLE_TIME_MS = 5;
  localparam int unsigned WRITE_CYCLE_CYCLES = (CLK_HZ / 1000) * WRITE_CYCLE_TIME_MS;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,
    ST_ADDR    = 5'h02,
    ST_ACK     = 5'h04,
    ST_ACTIVE  = 5'h08,
    ST_WRITING = 5'h10
  } fe_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic clk_rise;
    logic clk_fall;
    logic data;
  } bus_evt_s;

  typedef struct packed {
    logic [3:0] dev_type;
    logic [2:0] select;
    logic rw;
  } dev_addr_s;
endpackage

// file: src/bus_line_sync.sv
// synchroniser and event detector for the serial clock and data lines
`timescale 1ns/1ns
module bus_line_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // detected events
  output eeprom_fe_pkg::bus_evt_s evt_o
);
  import eeprom_fe_pkg::*;

  logic [2:0] scl_reg, scl_next;
  logic [2:0] sda_reg, sda_next;
  bus_evt_s evt_next;

  // two-stage sync then a history stage; stage 0 feeds stage 1 only
  always_comb begin
    scl_next = scl_reg;
    sda_next = sda_reg;
    if (ce_i) begin
      scl_next = {scl_reg[1:0], scl_i};
      sda_next = {sda_reg[1:0], sda_i};
    end
  end

  always_comb begin
    evt_next.clk_rise = scl_reg[1] & ~scl_reg[2];
    evt_next.clk_fall = ~scl_reg[1] & scl_reg[2];
    evt_next.start = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
    evt_next.stop = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];
    evt_next.data = sda_reg[1];
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      scl_reg <= SYNC_RST;
      sda_reg <= SYNC_RST;
      evt_o <= '0;
    end else if (ce_i) begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      evt_o <= evt_next;
    end
  end
endmodule

// file: verification/eeprom_fe_chk.sv
// assertion checker for the two-wire eeprom front end
`timescale 1ns/1ns
module eeprom_fe_chk #(
  parameter int unsigned WRITE_CYCLES = 50000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // bus and protect
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic write_protect_i,
  // watched outputs
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic rx_valid_o,
  input wire logic read_mode_o,
  input wire logic writing_o,
  input wire logic standby_o,
  input wire logic array_write_o
);
  int unsigned wcnt_reg;
  int unsigned wcnt_next;
  always_comb begin
    wcnt_next = writing_o ? wcnt_reg + 1 : 0;
  end
  always_ff @(posedge mclk_i) begin
    wcnt_reg <= wcnt_next;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_pull; sda_oe_o |-> !sda_o; endproperty
  a_pull: assert property (p_pull) else $error("data driven high");
  property p_rst; $rose(rst_b_i) |-> standby_o && !sda_oe_o && !writing_o; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_pulse; rx_valid_o |=> !rx_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("word strobe too long");
  property p_aw; array_write_o |-> rx_valid_o; endproperty
  a_aw: assert property (p_aw) else $error("array write without word");
  property p_wp; write_protect_i [*4] ##0 rx_valid_o |-> !array_write_o; endproperty
  a_wp: assert property (p_wp) else $error("write while protected");
  property p_busy; writing_o |-> !sda_oe_o; endproperty
  a_busy: assert property (p_busy) else $error("ack while writing");
  property p_wlen; writing_o |-> wcnt_reg <= WRITE_CYCLES; endproperty
  a_wlen: assert property (p_wlen) else $error("write cycle too long");
  property p_edge; $changed(sda_oe_o) |-> !$past(scl_i); endproperty
  a_edge: assert property (p_edge) else $error("data moved with clock high");
  property p_stop;
    read_mode_o && $past(scl_i) && scl_i && $rose(sda_i) |-> ##[1:8] standby_o;
  endproperty
  a_stop: assert property (p_stop) else $error("no standby after read stop");
endmodule

bind serial_eeprom_bus_front_end eeprom_fe_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_i (
  .mclk_i, .rst_b_i, .scl_i, .sda_i, .write_protect_i, .sda_o, .sda_oe_o,
  .rx_valid_o, .read_mode_o, .writing_o, .standby_o, .array_write_o);

// file: verification/bus_ctrl_model.sv
// two-wire bus controller model, open-drain data, clock still between frames
`timescale 1ns/1ns
module bus_ctrl_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic q;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_o = b;
    q;
    scl_o = 1'b1;
    q;
    q;
    r = sda_i;
    scl_o = 1'b0;
    q;
  endtask
  task automatic start;
    sda_o = 1'b1;
    q;
    scl_o = 1'b1;
    q;
    sda_o = 1'b0;
    q;
    scl_o = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_o = 1'b0;
    q;
    scl_o = 1'b1;
    q;
    sda_o = 1'b1;
    q;
    q;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] rd,
                      output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      rd[i] = r;
    end
    bit_x(a, r);
    ak = !r;
  endtask
  // start, nine clocks, start then stop
  task automatic recover;
    logic r;
    start;
    repeat (9) bit_x(1'b1, r);
    start;
    stop;
  endtask
endmodule

// file: verification/serial_eeprom_bus_front_end_bench.sv
// testbench for the two-wire eeprom front end
`timescale 1ns/1ns
module serial_eeprom_bus_front_end_bench;
  import eeprom_fe_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] sel = 3'h0;
  logic wp = 1'b0;
  logic txb = 1'b0;
  logic scl, sda_drv, sda_w, sda_o, sda_oe_o, ak;
  logic [7:0] rx_word_o, rd;
  logic rx_valid_o, selected_o, read_mode_o, writing_o, standby_o, array_write_o;
  int n_errors = 0;
  int tests_run = 0;
  int n_aw = 0;
  int n_rv = 0;
  always #50 mclk_i = ~mclk_i;
  assign sda_w = sda_drv && !(sda_oe_o && !sda_o);
  always @(posedge mclk_i) begin
    if (array_write_o === 1'b1) begin
      n_aw++;
    end
    if (rx_valid_o === 1'b1) begin
      n_rv++;
    end
  end
  bus_ctrl_model m (.clk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_drv));
  serial_eeprom_bus_front_end #(.WRITE_CYCLES(200)) serial_eeprom_bus_front_end_i (
    .mclk_i, .rst_b_i, .ce_i(1'b1), .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_o,
    .select_pin_high_i(sel[2]), .select_pin_mid_i(sel[1]), .select_pin_low_i(sel[0]),
    .write_protect_i(wp), .tx_bit_i(txb), .tx_en_i(1'b1), .rx_word_o, .rx_valid_o,
    .selected_o, .read_mode_o, .writing_o, .standby_o, .array_write_o);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic addr(input logic rw, input logic [7:0] exp);
    m.start;
    m.xfer({DEV_TYPE_DEFAULT, sel, rw}, 1'b1, rd, ak);
    cyc(4);
    chk("ack", 8'(ak), exp);
  endtask
  task automatic t_select;
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      txb = s[1];
      addr(s[0], 8'h1);
      chk("sel", 8'(selected_o), 8'h1);
      chk("rmode", 8'(read_mode_o), 8'(s[0]));
      if (s[0]) begin
        m.xfer(8'hff, !s[1], rd, ak);
        chk("rdata", rd, {8{s[1]}});
      end
      m.stop;
      cyc(4);
      chk("stby", 8'(standby_o), 8'h1);
      chk("nowr", 8'(writing_o), 8'h0);
    end
    $display("test select done");
  endtask
  task automatic t_nomatch;
    for (int i = 0; i < 2; i++) begin
      m.start;
      m.xfer(i ? {DEV_TYPE_DEFAULT, ~sel, 1'b0} : {~DEV_TYPE_DEFAULT, sel, 1'b0},
             1'b1, rd, ak);
      cyc(4);
      chk("nak", 8'(ak), 8'h0);
      chk("idle", 8'(standby_o), 8'h1);
      m.stop;
    end
    $display("test nomatch done");
  endtask
  task automatic t_write(input logic p);
    wp = p;
    n_aw = 0;
    n_rv = 0;
    addr(1'b0, 8'h1);
    m.xfer(8'ha5, 1'b1, rd, ak);
    cyc(4);
    chk("dack", 8'(ak), 8'h1);
    chk("word", rx_word_o, 8'ha5);
    chk("aw", 8'(n_aw), 8'(!p));
    chk("rv", 8'(n_rv), 8'h1);
    m.stop;
    cyc(2);
    chk("wr", 8'(writing_o), 8'(!p));
    if (!p) begin
      addr(1'b0, 8'h0);
      m.stop;
      for (int i = 0; i < 400 && writing_o !== 1'b0; i++) begin
        cyc(1);
      end
      chk("done", 8'(writing_o), 8'h0);
      if (writing_o !== 1'b0) begin
        stop_test;
      end
      chk("stbw", 8'(standby_o), 8'h1);
      addr(1'b0, 8'h1);
      m.stop;
    end
    wp = 1'b0;
    $display("test write done");
  endtask
  task automatic t_recover;
    m.start;
    m.bit_x(1'b1, ak);
    m.bit_x(1'b0, ak);
    addr(1'b0, 8'h1);
    m.recover;
    cyc(4);
    chk("rec", 8'(standby_o), 8'h1);
    addr(1'b0, 8'h1);
    m.stop;
    $display("test recover done");
  endtask
  initial begin
    cyc(3);
    rst_b_i = 1'b1;
    cyc(4);
    chk("stby0", 8'(standby_o), 8'h1);
    t_select;
    t_nomatch;
    t_write(1'b0);
    t_write(1'b1);
    t_recover;
    stop_test;
  end
endmodule
